// *** hw/fbp_defines.svh ***
// Constants for the flash block erase and protection controller
`ifndef FBP_DEFINES_SVH
`define FBP_DEFINES_SVH
`define FBP_WORDS 8192
`define FBP_ADDR_W 13
`define FBP_ERASE_BLOCKS 32
`define FBP_PROT_UNITS 16
`define FBP_WORDS_PER_BLOCK 256
`define FBP_BLK_LSB 8
`define FBP_PROT_LSB 9
`define FBP_ERASED_WORD 32'hFFFF_FFFF
`define FBP_PROT_RESET 2'h0
`endif

// *** hw/fbp_pkg.sv ***
// Types for the flash block erase and protection controller
package fbp_pkg;
	typedef enum logic [1:0] {
		FBP_PROT_OPEN = 2'h0,
		FBP_PROT_RO = 2'h1,
		FBP_PROT_XO = 2'h2
	} fbp_prot_t;
	typedef enum logic [1:0] {
		FBP_ST_IDLE = 2'b00,
		FBP_ST_ERASE = 2'b01
	} fbp_state_t;
endpackage

// *** hw/fbp_guard.sv ***
// Permission decision for one access from the addressed unit's setting
`timescale 1ns/1ps
`include "fbp_defines.svh"
module fbp_guard
	import fbp_pkg::*;
(
	// Setting of the addressed unit
	input wire logic [1:0] prot_i,
	// Access kind
	input wire logic is_write_i,
	input wire logic is_fetch_i,
	// Decision
	output logic allow_o
);
	always_comb begin
		allow_o = 1'b1;
		if (prot_i == FBP_PROT_RO && is_write_i) begin
			allow_o = 1'b0;
		end else if (prot_i == FBP_PROT_XO) begin
			allow_o = is_fetch_i && !is_write_i;
		end
	end
endmodule

// *** hw/fbp_ctrl.sv ***
// Flash array controller with erase blocks and protection units
`timescale 1ns/1ps
`include "fbp_defines.svh"
module fbp_ctrl
	import fbp_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic NRST_I,
	// Instruction fetch port
	input wire logic IFETCH_EN_I,
	input wire logic [12:0] IFETCH_ADDR_I,
	output logic [31:0] IFETCH_DATA_O,
	output logic IFETCH_OK_O,
	// Data read port, processor or debugger
	input wire logic DREAD_EN_I,
	input wire logic DREAD_DBG_I,
	input wire logic [12:0] DREAD_ADDR_I,
	output logic [31:0] DREAD_DATA_O,
	output logic DREAD_OK_O,
	// Program and erase commands
	input wire logic PROG_EN_I,
	input wire logic [12:0] PROG_ADDR_I,
	input wire logic [31:0] PROG_DATA_I,
	input wire logic ERASE_EN_I,
	input wire logic [4:0] ERASE_BLOCK_I,
	output logic BUSY_O,
	output logic DONE_O,
	// Protection settings
	input wire logic PROT_WR_I,
	input wire logic [3:0] PROT_UNIT_I,
	input wire logic [1:0] PROT_VAL_I,
	output logic [31:0] PROT_MAP_O,
	// Violation status
	input wire logic VIOL_CLR_I,
	output logic VIOL_O
);
	// =====================================================
	// Storage
	logic [31:0] mem [0:`FBP_WORDS-1];
	logic [1:0] prot [0:`FBP_PROT_UNITS-1];
	fbp_state_t state;
	logic [7:0] erase_idx;
	logic [4:0] erase_blk;

	function automatic logic [3:0] unit_of(input logic [12:0] a);
		unit_of = a[12:`FBP_PROT_LSB];
	endfunction

	// =====================================================
	// Permission checks
	logic f_ok, d_ok, p_ok, e_ok;
	logic [1:0] erase_prot;
	assign erase_prot = prot[erase_blk_in_unit(ERASE_BLOCK_I)];

	function automatic logic [3:0] erase_blk_in_unit(input logic [4:0] b);
		erase_blk_in_unit = b[4:1];
	endfunction

	fbp_guard u_fetch (.prot_i(prot[unit_of(IFETCH_ADDR_I)]),
		.is_write_i(1'b0), .is_fetch_i(1'b1), .allow_o(f_ok));
	fbp_guard u_dread (.prot_i(prot[unit_of(DREAD_ADDR_I)]),
		.is_write_i(1'b0), .is_fetch_i(1'b0), .allow_o(d_ok));
	fbp_guard u_prog (.prot_i(prot[unit_of(PROG_ADDR_I)]),
		.is_write_i(1'b1), .is_fetch_i(1'b0), .allow_o(p_ok));
	fbp_guard u_erase (.prot_i(erase_prot),
		.is_write_i(1'b1), .is_fetch_i(1'b0), .allow_o(e_ok));

	logic idle;
	assign idle = (state == FBP_ST_IDLE);
	assign BUSY_O = !idle;

	// =====================================================
	// Reads, one cycle
	always_ff @(posedge REF_CLK_I) begin
		if (!NRST_I) begin
			IFETCH_DATA_O <= 32'h0000_0000;
			IFETCH_OK_O <= 1'b0;
			DREAD_DATA_O <= 32'h0000_0000;
			DREAD_OK_O <= 1'b0;
		end else begin
			IFETCH_OK_O <= IFETCH_EN_I && f_ok;
			IFETCH_DATA_O <= (IFETCH_EN_I && f_ok) ?
				mem[IFETCH_ADDR_I] : 32'h0000_0000;
			// Debugger and processor data reads share this check
			DREAD_OK_O <= DREAD_EN_I && d_ok;
			DREAD_DATA_O <= (DREAD_EN_I && d_ok) ?
				mem[DREAD_ADDR_I] : 32'h0000_0000;
		end
	end

	// =====================================================
	// Program and erase sequencing
	// Erase clears one word per clock; the array has no reset
	always_ff @(posedge REF_CLK_I) begin
		if (!NRST_I) begin
			state <= FBP_ST_IDLE;
			erase_idx <= 8'h00;
			erase_blk <= 5'h00;
			DONE_O <= 1'b0;
		end else begin
			DONE_O <= 1'b0;
			case (state)
				FBP_ST_IDLE: begin
					if (ERASE_EN_I && e_ok) begin
						state <= FBP_ST_ERASE;
						erase_blk <= ERASE_BLOCK_I;
						erase_idx <= 8'h00;
					end else if (PROG_EN_I && p_ok) begin
						mem[PROG_ADDR_I] <= PROG_DATA_I;
						DONE_O <= 1'b1;
					end
				end
				FBP_ST_ERASE: begin
					mem[{erase_blk, erase_idx}] <= `FBP_ERASED_WORD;
					erase_idx <= erase_idx + 8'h01;
					if (erase_idx == 8'hFF) begin
						state <= FBP_ST_IDLE;
						DONE_O <= 1'b1;
					end
				end
				default: state <= FBP_ST_IDLE;
			endcase
		end
	end

	// =====================================================
	// Protection settings
	always_ff @(posedge REF_CLK_I) begin
		if (!NRST_I) begin
			for (int i = 0; i < `FBP_PROT_UNITS; i++) begin
				prot[i] <= `FBP_PROT_RESET;
			end
		end else if (PROT_WR_I) begin
			prot[PROT_UNIT_I] <= PROT_VAL_I;
		end
	end

	always_comb begin
		for (int i = 0; i < `FBP_PROT_UNITS; i++) begin
			PROT_MAP_O[2*i +: 2] = prot[i];
		end
	end

	// =====================================================
	// Violation flag, set wins over clear
	logic viol_evt;
	assign viol_evt = (IFETCH_EN_I && !f_ok) || (DREAD_EN_I && !d_ok) ||
		(idle && ERASE_EN_I && !e_ok) ||
		(idle && !ERASE_EN_I && PROG_EN_I && !p_ok);

	always_ff @(posedge REF_CLK_I) begin
		if (!NRST_I) begin
			VIOL_O <= 1'b0;
		end else if (viol_evt) begin
			VIOL_O <= 1'b1;
		end else if (VIOL_CLR_I) begin
			VIOL_O <= 1'b0;
		end
	end
endmodule

// *** dv/fbp_core_model.sv ***
// Core fetch-side model issuing random instruction fetches
`timescale 1ns/1ps
module fbp_core_model (
	input wire logic clk_i,
	output logic fe_o = 1'b0,
	output logic [12:0] fa_o = '0
);
	// Idle gaps and back-to-back fetches both occur
	always @(posedge clk_i) begin
		fe_o <= 1'($urandom);
		fa_o <= 13'($urandom);
	end
endmodule

// *** dv/fbp_ctrl_props.sv ***
// Assertion checker for the flash protection controller
`timescale 1ns/1ps
module fbp_ctrl_props (
	input wire logic REF_CLK_I, NRST_I, IFETCH_EN_I, IFETCH_OK_O,
	input wire logic DREAD_EN_I, DREAD_OK_O, PROG_EN_I, ERASE_EN_I,
	input wire logic BUSY_O, DONE_O, VIOL_CLR_I, VIOL_O,
	input wire logic [12:0] DREAD_ADDR_I, PROG_ADDR_I,
	input wire logic [4:0] ERASE_BLOCK_I,
	input wire logic [31:0] DREAD_DATA_O, PROT_MAP_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!NRST_I);
	// Two erase blocks share one setting
	wire [1:0] rp = PROT_MAP_O[{DREAD_ADDR_I[12:9], 1'b0}+:2];
	wire [1:0] pp = PROT_MAP_O[{PROG_ADDR_I[12:9], 1'b0}+:2];
	wire [1:0] ep = PROT_MAP_O[{ERASE_BLOCK_I[4:1], 1'b0}+:2];
	wire go = ERASE_EN_I && !BUSY_O;
	property p_fok; IFETCH_EN_I |=> IFETCH_OK_O; endproperty
	a_fok: assert property (p_fok) else $error("fetch");
	property p_rok; DREAD_EN_I && rp != 2 |=> DREAD_OK_O; endproperty
	a_rok: assert property (p_rok) else $error("read");
	property p_xo;
		DREAD_EN_I && rp == 2 |=> !DREAD_OK_O && !DREAD_DATA_O && VIOL_O;
	endproperty
	a_xo: assert property (p_xo) else $error("xo read");
	property p_pr; PROG_EN_I && !go && !BUSY_O && ^pp |=> !DONE_O && VIOL_O;
	endproperty
	a_pr: assert property (p_pr) else $error("prog");
	property p_er; go && ^ep |=> !BUSY_O && VIOL_O; endproperty
	a_er: assert property (p_er) else $error("erase ref");
	property p_el; go && !(^ep) |=> BUSY_O[*8]; endproperty
	a_el: assert property (p_el) else $error("erase run");
	property p_ed; $rose(BUSY_O) |-> ##[253:258] DONE_O; endproperty
	a_ed: assert property (p_ed) else $error("erase end");
	property p_vs; VIOL_O && !VIOL_CLR_I |=> VIOL_O; endproperty
	a_vs: assert property (p_vs) else $error("sticky");
	c_er: cover property (go && !(^ep));
	c_xo: cover property (DREAD_EN_I && rp == 2);
	c_pr: cover property (PROG_EN_I && ^pp);
endmodule
bind fbp_ctrl fbp_ctrl_props chk_u (.*);

// *** dv/fbp_ctrl_test.sv ***
// Self-checking bench for the flash protection controller
`timescale 1ns/1ps
module fbp_ctrl_test;
	logic c = 0, rn = 0, fe, de = 0, pe = 0, ee = 0, pw = 0, vc = 0;
	logic [12:0] fa, da = 0, pa = 0, a;
	logic [31:0] dd, pd = 0, map, d;
	logic [3:0] pu = 0;
	logic [1:0] pv = 0;
	logic dok, busy, viol;
	int num_errors = 0, num_checks = 0, cyc = 0;
	always #4 c = ~c;
	fbp_core_model core_u (.clk_i(c), .fe_o(fe), .fa_o(fa));
	fbp_ctrl dut_u (.REF_CLK_I(c), .NRST_I(rn), .IFETCH_EN_I(fe),
		.IFETCH_ADDR_I(fa), .IFETCH_DATA_O(), .IFETCH_OK_O(),
		.DREAD_EN_I(de), .DREAD_DBG_I(a[0]), .DREAD_ADDR_I(da),
		.DREAD_DATA_O(dd), .DREAD_OK_O(dok), .PROG_EN_I(pe),
		.PROG_ADDR_I(pa), .PROG_DATA_I(pd), .ERASE_EN_I(ee),
		.ERASE_BLOCK_I(pa[12:8]), .BUSY_O(busy), .DONE_O(), .PROT_WR_I(pw),
		.PROT_UNIT_I(pu), .PROT_VAL_I(pv), .PROT_MAP_O(map),
		.VIOL_CLR_I(vc), .VIOL_O(viol));
	task chk(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Strobes last one cycle; results read once that edge has landed
	task op(input logic r, p, e, w, k, input logic [1:0] v);
		@(posedge c);
		{de, pe, ee, pw, vc} <= {r, p, e, w, k};
		da <= a; pa <= a; pu <= a[12:9]; pv <= v;
		@(posedge c);
		{de, pe, ee, pw, vc} <= 0;
		#1;
		// Erase runs 256 cycles
		if (p | e) repeat (260) @(posedge c);
	endtask
	always @(posedge c) begin
		cyc++;
		if (cyc > 20000) begin
			num_errors++;
			final_report;
		end
	end
	initial begin
		a = 0;
		void'($urandom(32'he884_e3a9));
		repeat (12) @(posedge c);
		rn <= 1;
		#1 chk("map0", map, 0);
		repeat (4) begin
			a = 13'($urandom);
			op(0, 0, 1, 0, 0, 0);
			op(1, 0, 0, 0, 0, 0);
			chk("erased", dd, 32'hffff_ffff);
			d = $urandom;
			pd <= d;
			op(0, 1, 0, 0, 0, 0);
			op(1, 0, 0, 0, 0, 0);
			chk("prog", dd, d);
			chk("prog_ok", 32'(dok), 32'h0000_0001);
			pd <= ~d;
			for (int v = 1; v < 3; v++) begin
				op(0, 0, 0, 1, 0, 2'(v));
				chk("map", map[{a[12:9], 1'b0}+:2], v);
				op(0, 1, 0, 0, 0, 0);
				op(0, 0, 1, 0, 0, 0);
				chk("viol", viol, 1);
				op(1, 0, 0, 0, 0, 0);
				chk("kept", dd, v == 2 ? 0 : d);
				op(0, 0, 0, 0, 1, 0);
				chk("clr", viol, 0);
			end
			op(0, 0, 0, 1, 0, 0);
			// Unit open again: execute-only refusals must have kept the word
			op(1, 0, 0, 0, 0, 0);
			chk("xo_kept", dd, d);
		end
		final_report;
	end
endmodule
